// ===== src/can_mb_map.svh
// Register offsets, field positions, reset values and sizes of the mailbox filter block
`ifndef CAN_MB_MAP_SVH
`define CAN_MB_MAP_SVH

// ---------------------------------------------------------------
// Sizes
// ---------------------------------------------------------------
`define CANMB_MAILBOXES     32
`define CANMB_MASKS         8
`define CANMB_ADDR_W        10

// ---------------------------------------------------------------
// Byte offsets on the register bus
// ---------------------------------------------------------------
`define CANMB_SLOT_BASE     10'h000
`define CANMB_SLOT_END      10'h1FF
`define CANMB_AMASK_BASE    10'h200
`define CANMB_MDIS_OFS      10'h220
`define CANMB_CTRL_OFS      10'h224
`define CANMB_STAT_OFS      10'h228
`define CANMB_FLAGS_OFS     10'h22C
`define CANMB_CNT_OFS       10'h230
`define CANMB_SRCH_OFS      10'h234
`define CANMB_MCTL_BASE     10'h240

// ---------------------------------------------------------------
// Control word fields and values
// ---------------------------------------------------------------
`define CANMB_OPM_LSB       0
`define CANMB_ID_FORMAT_MODE_LSB      8
`define CANMB_BIG_BIT       16
`define CANMB_OPM_RESET_ON  2'h1
`define CANMB_OPM_FORCE     2'h3
`define CANMB_ID_FORMAT_MODE_EXT      2'h1
`define CANMB_ID_FORMAT_MODE_MIXED    2'h2

// ---------------------------------------------------------------
// Message slot byte layout and reset values
// ---------------------------------------------------------------
`define CANMB_IDE_BIT       7
`define CANMB_W1_KEEP       32'hFFFF_0F00
`define CANMB_ECS_KEEP      8'h80
`define CANMB_OPM_INIT      2'h1
`define CANMB_SRES_NONE     8'h80

`endif

// ===== src/can_mb_pkg.sv
// Types shared by the mailbox filter block
package can_mb_pkg;

   // ------------------------------------------------------------
   // Mode sequencer states
   // ------------------------------------------------------------
   typedef enum logic [1:0]
   {
      MODE_OPERATE = 2'b00,
      MODE_DRAIN   = 2'b01,
      MODE_RESET   = 2'b10
   } mode_state_t;

   // ------------------------------------------------------------
   // Bus carriers
   // ------------------------------------------------------------
   typedef struct packed
   {
      logic        read;
      logic        write;
      logic [9:0]  address;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } avm_req_t;

   typedef struct packed
   {
      logic        waitrequest;
      logic [31:0] readdata;
   } avm_rsp_t;

   typedef struct packed
   {
      logic        valid;
      logic        ide;
      logic [28:0] id;
   } probe_t;

   // ------------------------------------------------------------
   // Whole state of the block
   // ------------------------------------------------------------
   typedef struct packed
   {
      mode_state_t        mode;
      logic               ack;
      logic [31:0]        rdata;
      logic [7:0][31:0]   amask;
      logic [31:0]        mdis;
      logic [1:0]         opm;
      logic [1:0]         id_format_mode;
      logic               big;
      logic [31:0][7:0]   mctl;
      logic [7:0]         eflags;
      logic [7:0]         ecs;
      logic [7:0]         tctl;
      logic [7:0]         rec;
      logic [7:0]         tec;
      logic [15:0]        tstamp;
      logic [7:0]         sres;
      logic [1:0]         smode;
      logic [7:0]         rfc;
      logic [7:0]         tfc;
      logic               tx_busy;
      logic               rx_busy;
      logic               abort;
      logic [31:0]        match;
      logic               mvalid;
      logic [127:0][31:0] slot;
   } state_t;

endpackage : can_mb_pkg

// ===== src/can_mailbox_filter_reset.sv
// Mailbox store, acceptance filter and reset-mode sequencer of one CAN channel
//
// Summary of operation
// - A one in an acceptance mask bit makes that identifier bit compared, a zero ignores it.
// - Eight independent acceptance masks exist, each with standard and extended fields.
// - A 32-bit mask disable vector turns masking off for each mailbox set to one.
// - Slot bytes 0 to 3 carry the extension flag, remote flag, standard and extended ID.
// - Bytes 4 and 5 are a reserved byte and the length nibble, then data and a stamp.
// - The extension flag works only in mixed ID format and otherwise reads as zero.
// - Software reset sets and holds the control, status, flag, counter and FIFO state.
// - Mode 01 waits for a running transmission but not for a running reception.
// - Mode 11 enters reset mode at once and abandons bus activity.
// - Slot accesses follow a selectable little or big endian byte order.
`timescale 1ns/1ps
`include "can_mb_map.svh"

module can_mailbox_filter_reset
   import can_mb_pkg::*;
#(
   parameter int MAILBOXES = `CANMB_MAILBOXES
)
(
   input  wire logic     clock_i,
   input  wire logic     rst_i,
   input  wire avm_req_t avm_req_i,
   output avm_rsp_t      avm_rsp_o,
   input  wire logic     tx_busy_i,
   input  wire logic     rx_busy_i,
   input  wire probe_t   probe_i,
   output logic          reset_mode_o,
   output logic          abort_o,
   output logic [31:0]   match_o,
   output logic          match_valid_o
);

   // ------------------------------------------------------------
   // Elaboration check
   // ------------------------------------------------------------
   if (MAILBOXES < 4 || MAILBOXES > `CANMB_MAILBOXES || (MAILBOXES % 4) != 0)
   begin : g_bad_size
      $error("MAILBOXES must be a multiple of 4 from 4 to 32");
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Byte lanes a legal access may use
   function automatic logic lanes_ok(input logic [3:0] be);
      lanes_ok = (be == 4'h1) || (be == 4'h2) || (be == 4'h4) || (be == 4'h8) ||
                 (be == 4'h3) || (be == 4'hC) || (be == 4'hF);
   endfunction : lanes_ok

   // Merge written lanes into an old word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] be);
      merge = old;
      for (int b = 0; b < 4; b++)
      begin
         if (be[b])
         begin
            merge[8*b +: 8] = wd[8*b +: 8];
         end
      end
   endfunction : merge

   // Reverse the byte order of a word
   function automatic logic [31:0] swap32(input logic [31:0] x);
      swap32 = {x[7:0], x[15:8], x[23:16], x[31:24]};
   endfunction : swap32

   // Reverse the lane order of a byte enable
   function automatic logic [3:0] swap4(input logic [3:0] x);
      swap4 = {x[0], x[1], x[2], x[3]};
   endfunction : swap4

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   state_t      st;
   state_t      next_st;
   logic [9:0]  addr;
   logic [7:0]  widx;
   logic [4:0]  slot_mb;
   logic [31:0] wd;
   logic [3:0]  be;
   logic        req;
   logic        do_wr;
   logic [31:0] rd;
   logic [31:0] sw;
   logic [3:0]  sbe;
   logic [31:0] word0;
   logic [10:0] m_sid;
   logic [17:0] m_eid;
   logic        m_ide;
   logic [31:0] m_mask;
   logic        hit;
   logic [1:0]  new_opm;
   logic        opm_wr;

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb
   begin
      next_st = st;
      addr    = avm_req_i.address;
      widx    = addr[9:2];
      slot_mb = widx[6:2];
      wd      = avm_req_i.writedata;
      be      = avm_req_i.byteenable;
      req     = (avm_req_i.read || avm_req_i.write) && !st.ack;
      // Writes land at the edge that completes the transfer (waitrequest low)
      do_wr   = avm_req_i.write && st.ack && lanes_ok(be);
      rd      = 32'h0000_0000;
      sw      = st.big ? swap32(wd) : wd;
      sbe     = st.big ? swap4(be) : be;
      word0   = 32'h0000_0000;
      m_sid   = 11'h000;
      m_eid   = 18'h00000;
      m_ide   = 1'b0;
      m_mask  = 32'h0000_0000;
      hit     = 1'b0;
      new_opm = wd[`CANMB_OPM_LSB +: 2];
      opm_wr  = 1'b0;

      // Handshake: waitrequest drops one cycle after the request
      next_st.ack   = req;
      next_st.abort = 1'b0;

      // Free-running stamp outside reset mode
      if (st.mode != MODE_RESET)
      begin
         next_st.tstamp = st.tstamp + 16'h0001;
      end
      next_st.tx_busy = tx_busy_i;
      next_st.rx_busy = rx_busy_i;

      // Read path and write path, decoded by address
      if (addr <= `CANMB_SLOT_END && int'(slot_mb) < MAILBOXES)
      begin
         rd = st.slot[widx[6:0]];
         if (widx[1:0] == 2'h0 && st.id_format_mode != `CANMB_ID_FORMAT_MODE_MIXED)
         begin
            rd[`CANMB_IDE_BIT] = 1'b0;
         end
         rd = st.big ? swap32(rd) : rd;
         if (do_wr)
         begin
            next_st.slot[widx[6:0]] = merge(st.slot[widx[6:0]], sw, sbe);
            if (widx[1:0] == 2'h0 && st.id_format_mode != `CANMB_ID_FORMAT_MODE_MIXED)
            begin
               next_st.slot[widx[6:0]][`CANMB_IDE_BIT] = 1'b0;
            end
            if (widx[1:0] == 2'h1)
            begin
               next_st.slot[widx[6:0]] = next_st.slot[widx[6:0]] & `CANMB_W1_KEEP;
            end
         end
      end
      else if (addr >= `CANMB_AMASK_BASE && addr < `CANMB_MDIS_OFS)
      begin
         rd = st.amask[widx[2:0]];
         if (do_wr)
         begin
            next_st.amask[widx[2:0]] = merge(st.amask[widx[2:0]], wd, be) & 32'h1FFF_FFFF;
         end
      end
      else if (addr == `CANMB_MDIS_OFS)
      begin
         rd = st.mdis;
         if (do_wr)
         begin
            next_st.mdis = merge(st.mdis, wd, be);
         end
      end
      else if (addr == `CANMB_CTRL_OFS)
      begin
         rd = {15'h0000, st.big, 6'h00, st.id_format_mode, 6'h00, st.opm};
         if (do_wr)
         begin
            if (be[0])
            begin
               next_st.opm = new_opm;
               opm_wr      = 1'b1;
            end
            if (be[1])
            begin
               next_st.id_format_mode = wd[`CANMB_ID_FORMAT_MODE_LSB +: 2];
            end
            if (be[2])
            begin
               next_st.big = wd[`CANMB_BIG_BIT];
            end
         end
      end
      else if (addr == `CANMB_STAT_OFS)
      begin
         rd = {28'h000_0000, st.rx_busy, st.tx_busy, st.mode == MODE_DRAIN,
               st.mode == MODE_RESET};
      end
      else if (addr == `CANMB_FLAGS_OFS)
      begin
         rd = {8'h00, st.tctl, st.ecs, st.eflags};
         if (do_wr)
         begin
            {next_st.tctl, next_st.ecs, next_st.eflags} =
               24'(merge(rd, wd, be));
         end
      end
      else if (addr == `CANMB_CNT_OFS)
      begin
         rd = {st.tstamp, st.tec, st.rec};
         if (do_wr)
         begin
            {next_st.tec, next_st.rec} = 16'(merge(rd, wd, be));
         end
      end
      else if (addr == `CANMB_SRCH_OFS)
      begin
         rd = {st.tfc, st.rfc, 6'h00, st.smode, st.sres};
         if (do_wr)
         begin
            next_st.smode = 2'(merge(rd, wd, be) >> 8);
            next_st.rfc   = 8'(merge(rd, wd, be) >> 16);
            next_st.tfc   = 8'(merge(rd, wd, be) >> 24);
         end
      end
      else if (addr >= `CANMB_MCTL_BASE && widx[7:3] == 5'h12)
      begin
         rd = st.mctl[widx[2:0]*4 +: 4];
         if (do_wr)
         begin
            next_st.mctl[widx[2:0]*4 +: 4] = merge(st.mctl[widx[2:0]*4 +: 4], wd, be);
         end
      end
      if (req && avm_req_i.read)
      begin
         next_st.rdata = rd;
      end

      // Mode sequencer
      case (st.mode)
         MODE_OPERATE:
         begin
            if (opm_wr && new_opm == `CANMB_OPM_FORCE)
            begin
               next_st.mode  = MODE_RESET;
               next_st.abort = 1'b1;
            end
            else if (opm_wr && new_opm == `CANMB_OPM_RESET_ON)
            begin
               next_st.mode = tx_busy_i ? MODE_DRAIN : MODE_RESET;
            end
         end
         MODE_DRAIN:
         begin
            if (opm_wr && new_opm == `CANMB_OPM_FORCE)
            begin
               next_st.mode  = MODE_RESET;
               next_st.abort = 1'b1;
            end
            else if (opm_wr && !new_opm[0])
            begin
               next_st.mode = MODE_OPERATE;
            end
            else if (!tx_busy_i)
            begin
               next_st.mode = MODE_RESET;
            end
         end
         MODE_RESET:
         begin
            if (opm_wr && !new_opm[0])
            begin
               next_st.mode = MODE_OPERATE;
            end
         end
         default:
         begin
            next_st.mode = MODE_RESET;
         end
      endcase

      // Held values throughout reset mode
      if (next_st.mode == MODE_RESET)
      begin
         next_st.mctl   = '0;
         next_st.eflags = 8'h00;
         next_st.rec    = 8'h00;
         next_st.tec    = 8'h00;
         next_st.tstamp = 16'h0000;
         next_st.sres   = `CANMB_SRES_NONE;
         next_st.smode  = 2'h0;
         next_st.rfc    = 8'h00;
         next_st.tfc    = 8'h00;
         next_st.tctl   = 8'h00;
         next_st.ecs    = next_st.ecs & `CANMB_ECS_KEEP;
         next_st.match  = '0;                                            // No stale hits
      end

      // Acceptance filter across all mailboxes
      next_st.mvalid = probe_i.valid && next_st.mode != MODE_RESET;
      if (probe_i.valid)
      begin
         next_st.match = 32'h0000_0000;
         for (int j = 0; j < MAILBOXES; j++)
         begin
            word0 = st.slot[4*j];
            m_sid = {word0[4:0], word0[15:10]};
            m_eid = {word0[9:8], word0[23:16], word0[31:24]};
            m_ide = (st.id_format_mode == `CANMB_ID_FORMAT_MODE_MIXED) ? word0[`CANMB_IDE_BIT] :
                    (st.id_format_mode == `CANMB_ID_FORMAT_MODE_EXT);
            m_mask = st.mdis[j] ? 32'hFFFF_FFFF : st.amask[j/4];
            hit = (m_ide == probe_i.ide) &&
                  (((m_sid ^ probe_i.id[28:18]) & m_mask[28:18]) == 11'h000) &&
                  (!m_ide || ((m_eid ^ probe_i.id[17:0]) & m_mask[17:0]) == 18'h00000);
            next_st.match[j] = hit && next_st.mode != MODE_RESET;
         end
         if (next_st.mode != MODE_RESET)
         begin
            next_st.sres = `CANMB_SRES_NONE;
            for (int j = MAILBOXES - 1; j >= 0; j--)
            begin
               if (next_st.match[j])
               begin
                  next_st.sres = 8'(j);
               end
            end
         end
      end
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         st      <= '0;
         st.mode <= MODE_RESET;
         st.opm  <= `CANMB_OPM_INIT;
         st.sres <= `CANMB_SRES_NONE;
      end
      else
      begin
         st <= next_st;
      end
   end

   // ------------------------------------------------------------
   // Outputs, all from the state register
   // ------------------------------------------------------------
   assign avm_rsp_o.waitrequest = !st.ack;
   assign avm_rsp_o.readdata    = st.rdata;
   assign reset_mode_o          = st.mode[1];      // Only reset mode sets bit 1
   assign abort_o               = st.abort;
   assign match_o               = st.match;
   assign match_valid_o         = st.mvalid;

endmodule : can_mailbox_filter_reset

// ===== tb/can_mb_properties.sv
// Concurrent checks on the ports of the mailbox filter block
`timescale 1ns/1ps
`include "can_mb_map.svh"

module can_mb_properties
   import can_mb_pkg::*;
(
   input wire logic        clock_i,
   input wire logic        rst_i,
   input wire avm_req_t    avm_req_i,
   input wire avm_rsp_t    avm_rsp_o,
   input wire logic        tx_busy_i,
   input wire logic        rx_busy_i,
   input wire probe_t      probe_i,
   input wire logic        reset_mode_o,
   input wire logic        abort_o,
   input wire logic [31:0] match_o,
   input wire logic        match_valid_o
);
   // ---------------------------------------------------------------
   // Helper: control write taken at this edge
   // ---------------------------------------------------------------
   logic       ctl_wr;
   logic [1:0] ctl_opm;
   logic       force_wr;

   // Mode write detection, at the edge where the write lands
   assign ctl_wr = avm_req_i.write && !avm_rsp_o.waitrequest && avm_req_i.byteenable[0]
      && ({avm_req_i.address[9:2], 2'b00} == `CANMB_CTRL_OFS);
   assign ctl_opm = avm_req_i.writedata[1:0];
   assign force_wr = ctl_wr && (ctl_opm == 2'h3) && !reset_mode_o;

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   bus_answer_a: assert property ((avm_req_i.read || avm_req_i.write) && avm_rsp_o.waitrequest
      |=> !avm_rsp_o.waitrequest) else $error("bus answer late");
   answer_pulse_a: assert property (!avm_rsp_o.waitrequest |=> avm_rsp_o.waitrequest)
      else $error("waitrequest low too long");
   force_entry_a: assert property (force_wr |=> reset_mode_o && abort_o)
      else $error("forced entry missing");
   abort_cause_a: assert property (abort_o |-> $past(force_wr) ##1 !abort_o)
      else $error("abort without forced write");
   gentle_entry_a: assert property (ctl_wr && ctl_opm == 2'h1 && !tx_busy_i |=> reset_mode_o)
      else $error("reset entry late");
   drain_wait_a: assert property (!reset_mode_o && tx_busy_i && !ctl_wr |=> !reset_mode_o)
      else $error("entry during transmission");
   mode_hold_a: assert property (reset_mode_o && !ctl_wr |=> reset_mode_o)
      else $error("reset mode left");
   match_time_a: assert property (probe_i.valid && !reset_mode_o
      |=> match_valid_o == !reset_mode_o)
      else $error("match result missing");
   match_cause_a: assert property (match_valid_o |-> $past(probe_i.valid))
      else $error("match without probe");
   reset_quiet_a: assert property (reset_mode_o && $past(reset_mode_o)
      |-> !match_valid_o && match_o == 32'h0) else $error("match in reset mode");

   // Main scenarios
   cover property (ctl_wr && ctl_opm == 2'h3 && tx_busy_i);
   cover property ($rose(reset_mode_o) && rx_busy_i);
   cover property (match_valid_o && match_o != 32'h0);
endmodule : can_mb_properties

// ===== tb/can_node_model.sv
// Far-side model: other bus nodes making bus activity and received identifiers
`timescale 1ns/1ps

module can_node_model
   import can_mb_pkg::*;
(
   input  wire logic clock_i,
   output logic      tx_busy_o,
   output logic      rx_busy_o,
   output probe_t    probe_o
);
   // ---------------------------------------------------------------
   // Idle bus at time zero
   // ---------------------------------------------------------------
   initial
   begin
      tx_busy_o = 1'b0;
      rx_busy_o = 1'b0;
      probe_o = '0;
   end

   // One received identifier, lines scrambled once released
   task automatic send_id(input logic ide, input logic [28:0] id);
      @(posedge clock_i);
      probe_o <= '{valid: 1'b1, ide: ide, id: id};
      @(posedge clock_i);
      probe_o <= '{valid: 1'b0, ide: ~ide, id: ~id};
   endtask : send_id

   // Bus activity levels seen by the channel
   task automatic set_busy(input logic tx, input logic rx);
      @(posedge clock_i);
      tx_busy_o <= tx;
      rx_busy_o <= rx;
   endtask : set_busy
endmodule : can_node_model

// ===== tb/can_mailbox_filter_reset_tb.sv
// Self-checking bench of the mailbox filter block
`timescale 1ns/1ps
`include "can_mb_map.svh"

module can_mailbox_filter_reset_tb
   import can_mb_pkg::*;
;
   logic        clock_i;
   logic        rst_i;
   avm_req_t    req;
   avm_rsp_t    rsp;
   logic        tx_busy;
   logic        rx_busy;
   probe_t      probe;
   logic        reset_mode;
   logic        abort;
   logic [31:0] match;
   logic        match_valid;
   int          mismatches;
   int          checks;
   int          aborts;

   // ---------------------------------------------------------------
   // Design, far side and clock
   // ---------------------------------------------------------------
   can_mailbox_filter_reset i_dut (.clock_i(clock_i), .rst_i(rst_i), .avm_req_i(req),
      .avm_rsp_o(rsp), .tx_busy_i(tx_busy), .rx_busy_i(rx_busy), .probe_i(probe),
      .reset_mode_o(reset_mode), .abort_o(abort), .match_o(match),
      .match_valid_o(match_valid));

   can_node_model i_node (.clock_i(clock_i), .tx_busy_o(tx_busy), .rx_busy_o(rx_busy),
      .probe_o(probe));

   initial
   begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end

   // Abort pulse counter
   always @(posedge clock_i)
      if (abort === 1'b1) aborts++;

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic conclude;
      $display("mismatches %0d checks %0d", mismatches, checks);
      if (mismatches == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : conclude

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // One Avalon transfer, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d,
                      input logic [3:0] be, output logic [31:0] q);
      int n;
      @(posedge clock_i);
      req <= '{read: !wr, write: wr, address: a, writedata: d, byteenable: be};
      n = 0;
      do
      begin
         @(posedge clock_i);
         n++;
      end
      while (rsp.waitrequest !== 1'b0 && n < 40);
      q = rsp.readdata;
      req.read <= 1'b0;
      req.write <= 1'b0;
      if (n >= 40)
      begin
         mismatches++;
         conclude();
      end
   endtask : bus

   task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] be);
      logic [31:0] q;
      bus(1'b1, a, d, be, q);
   endtask : wr

   task automatic rdc(input logic [9:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, 4'hF, q);
      check(q, exp);
   endtask : rdc

   // Standard frame probe, result looked at one cycle later
   task automatic probe_chk(input logic [10:0] standard_id_bits, input logic [31:0] exp, input logic v);
      i_node.send_id(1'b0, {standard_id_bits, 18'h0});
      @(negedge clock_i);
      check(match, exp);
      check({31'h0, match_valid}, {31'h0, v});
   endtask : probe_chk

   // Hang guard
   initial
   begin
      repeat (20000) @(posedge clock_i);
      mismatches++;
      conclude();
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial
   begin
      rst_i = 1'b1;
      req = '0;
      mismatches = 0;
      checks = 0;
      aborts = 0;
      repeat (6) @(posedge clock_i);
      rst_i <= 1'b0;
      // Reset state and an unmapped place
      rdc(`CANMB_CTRL_OFS, 32'h0000_0001);
      rdc(`CANMB_SRCH_OFS, {24'h0, `CANMB_SRES_NONE});
      rdc(10'h3F0, 32'h0);
      // Operate in mixed format, masks all compared, one bit left out
      wr(`CANMB_CTRL_OFS, 32'h0000_0200, 4'hF);
      for (int k = 0; k < 8; k++)
         wr(`CANMB_AMASK_BASE + 10'(4 * k), 32'hFFFF_FFFF, 4'hF);
      wr(`CANMB_AMASK_BASE + 10'h4, 32'h1FFB_FFFF, 4'hF);
      rdc(`CANMB_AMASK_BASE + 10'h4, 32'h1FFB_FFFF);
      rdc(`CANMB_AMASK_BASE + 10'h8, 32'h1FFF_FFFF);
      wr(10'h050, 32'h0000_8C04, 4'hF);
      probe_chk(11'h122, 32'h0000_0020, 1'b1);
      rdc(`CANMB_SRCH_OFS, 32'h0000_0005);
      wr(`CANMB_MDIS_OFS, 32'h0000_0020, 4'hF);
      rdc(`CANMB_MDIS_OFS, 32'h0000_0020);
      probe_chk(11'h122, 32'h0000_0000, 1'b1);
      // Extension flag gating
      wr(10'h060, 32'h0000_0080, 4'hF);
      rdc(10'h060, 32'h0000_0080);
      wr(`CANMB_CTRL_OFS, 32'h0, 4'hF);
      rdc(10'h060, 32'h0);
      // Reserved byte and length nibble
      wr(10'h064, 32'hFFFF_FFFF, 4'hF);
      rdc(10'h064, `CANMB_W1_KEEP);
      // Byte order, then lane rules
      wr(`CANMB_CTRL_OFS, 32'h0001_0000, 4'hF);
      wr(10'h078, 32'h1122_3344, 4'hF);
      rdc(10'h078, 32'h1122_3344);
      wr(`CANMB_CTRL_OFS, 32'h0, 4'hF);
      rdc(10'h078, 32'h4433_2211);
      wr(10'h078, 32'hFFFF_FFFF, 4'b0101);
      wr(10'h078, 32'h0000_AA00, 4'b0010);
      rdc(10'h078, 32'h4433_AA11);
      // Graceful entry waits for transmission, not reception
      wr(`CANMB_FLAGS_OFS, 32'h00FF_FFFF, 4'hF);
      wr(`CANMB_MCTL_BASE, 32'h0000_00FF, 4'hF);
      rdc(`CANMB_FLAGS_OFS, 32'h00FF_FFFF);
      i_node.set_busy(1'b1, 1'b1);
      wr(`CANMB_CTRL_OFS, 32'h0000_0001, 4'hF);
      repeat (3) @(posedge clock_i);
      rdc(`CANMB_STAT_OFS, 32'h0000_000E);
      check({31'h0, reset_mode}, 32'h0);
      i_node.set_busy(1'b0, 1'b1);
      @(posedge clock_i);
      @(negedge clock_i);
      check({31'h0, reset_mode}, 32'h1);
      // Held state in reset mode
      rdc(`CANMB_FLAGS_OFS, {16'h0, `CANMB_ECS_KEEP, 8'h0});
      rdc(`CANMB_MCTL_BASE, 32'h0);
      wr(`CANMB_FLAGS_OFS, 32'hFFFF_FFFF, 4'hF);
      rdc(`CANMB_FLAGS_OFS, {16'h0, `CANMB_ECS_KEEP, 8'h0});
      rdc(`CANMB_CNT_OFS, 32'h0);
      probe_chk(11'h000, 32'h0, 1'b0);
      // Forced entry during a transmission
      wr(`CANMB_CTRL_OFS, 32'h0, 4'hF);
      i_node.set_busy(1'b1, 1'b0);
      @(negedge clock_i);
      check({31'h0, reset_mode}, 32'h0);
      wr(`CANMB_CTRL_OFS, 32'h0000_0003, 4'hF);
      @(negedge clock_i);
      check({31'h0, reset_mode}, 32'h1);
      check({31'h0, abort}, 32'h1);
      @(negedge clock_i);
      check({31'h0, abort}, 32'h0);
      check(32'(aborts), 32'h1);
      conclude();
   end
endmodule : can_mailbox_filter_reset_tb

bind can_mailbox_filter_reset can_mb_properties i_props (.clock_i(clock_i), .rst_i(rst_i),
   .avm_req_i(avm_req_i), .avm_rsp_o(avm_rsp_o), .tx_busy_i(tx_busy_i),
   .rx_busy_i(rx_busy_i), .probe_i(probe_i), .reset_mode_o(reset_mode_o),
   .abort_o(abort_o), .match_o(match_o), .match_valid_o(match_valid_o));
